// ==== bench/nvm_device_model.sv ====
// Behavioural target device on the serial programming port
`timescale 1ns/1ps
module nvm_device_model (
	input  wire logic        aclk,
	input  wire logic        ser_clk,
	input  wire logic        ser_in,
	input  wire logic [7:0]  latch_val,
	output logic             ser_out,
	output logic             got_stb,
	output logic [3:0]       got_cmd,
	output logic [15:0]      got_opnd,
	output int               hi_len,
	output int               lo_len
);
	logic        c_q  = 1'b0;
	logic        drv  = 1'b0;
	logic [19:0] sh   = '0;
	logic [3:0]  cmd4 = '0;
	int          n    = 0;
	int          hc   = 0;
	int          lc   = 0;
	int          hmax = 0;
	int          lmax = 0;
	initial
	begin
		ser_out = 1'b0;
		got_stb = 1'b0;
	end
	// =====================================================
	// Sample the link clock, shift bits, time the phases
	always @(posedge aclk)
	begin
		logic [19:0] nw;
		nw = {ser_in, sh[19:1]};
		c_q <= ser_clk;
		got_stb <= 1'b0;
		hc <= ser_clk ? hc + 1 : 0;
		lc <= ser_clk ? 0 : lc + 1;
		if (!drv)
			ser_out <= ~ser_out; // Released line keeps moving
		if (ser_clk && !c_q)
		begin
			if (n > 0 && lc > lmax)
				lmax <= lc;
			if (cmd4 == 4'h2 && n >= 12)
			begin
				drv <= 1'b1;
				ser_out <= latch_val[n-12];
			end
		end
		if (!ser_clk && c_q)
		begin
			sh <= nw;
			n <= (n == 19) ? 0 : n + 1;
			if (hc > hmax)
				hmax <= hc;
			if (n == 3)
				cmd4 <= nw[19:16];
			if (n == 19)
			begin
				got_stb <= 1'b1;
				got_cmd <= nw[3:0];
				got_opnd <= nw[19:4];
				hi_len <= (hc > hmax) ? hc : hmax;
				lo_len <= lmax;
				hmax <= 0;
				lmax <= 0;
				drv <= 1'b0;
				cmd4 <= 4'h0;
			end
		end
	end
endmodule : nvm_device_model

// ==== bench/serial_nvm_modify_sequencer_test.sv ====
// Self-checking bench for the serial programming controller
`timescale 1ns/1ps
`include "serial_nvm_params.svh"
module serial_nvm_modify_sequencer_test;
	localparam int PROG  = 20;
	localparam int CFG   = 30;
	localparam int DISCH = 10;
	localparam logic [7:0] A_OP  = `SNM_ADDR_OPERAND;
	localparam logic [7:0] A_CMD = `SNM_ADDR_COMMAND;
	localparam logic [7:0] A_ST  = `SNM_ADDR_STATUS;
	localparam logic [1:0] OK    = `SNM_RESP_OKAY;
	localparam logic [1:0] ERR   = `SNM_RESP_SLVERR;
	logic        aclk    = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr  = '0;
	logic [7:0]  araddr  = '0;
	logic [31:0] wdata   = '0;
	logic [3:0]  wstrb   = '0;
	logic        awvalid = 1'b0;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	logic [7:0]  latch_v = 8'h00;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic        sclk, line_in, line_out, line_oe, dev_out, got_stb;
	logic [3:0]  got_cmd;
	logic [15:0] got_opnd;
	int          hi_len, lo_len;
	int          cyc = 0;
	int          bad_count = 0;
	int          checks_done = 0;
	logic [1:0]  bq[$];
	logic [33:0] rq[$];
	logic [19:0] iq[$];
	logic [3:0]  cmds[9] = '{4'h0, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC,
		4'hD, 4'hE, 4'hF};
	logic [21:0] scr[43] = '{
		22'h8EA60, 22'h9CA60, 22'h84A60,
		22'h0E200, 22'h6EF80, 22'h0E000,
		22'h6EF70, 22'h0E000, 22'h6EF60,
		22'hA1B2D, 22'hC3D4D, 22'hE5F6D, 22'h0718F, 22'h100000,
		22'h8CA60, 22'h0E300, 22'h6EF80, 22'h0E000, 22'h6EF70, 22'h0E000,
		22'h6EF60, 22'h00C5F, 22'h100000,
		22'h0E010, 22'h6EF60, 22'h3A00F, 22'h200000,
		22'h9CA60, 22'h0E000, 22'h6EF80, 22'h0E070, 22'h6EF70,
		22'h88A60, 22'h82A60, 22'h00000, 22'h00000,
		22'h9EA60, 22'h84A60, 22'h82A60, 22'h00000, 22'h00000,
		22'h94A60, 22'h82A60};
	assign line_in = line_oe ? line_out : dev_out;
	always #5 aclk = ~aclk;
	serial_nvm_modify_sequencer #(.HALF_CYC(4), .TURN_CYC(4),
		.PROG_CYC(PROG), .CFG_CYC(CFG), .DISCH_CYC(DISCH)) dut_u (
		.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr),
		.s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
		.s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
		.s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
		.s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
		.s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
		.s_rready(rready), .prog_serial_clock(sclk),
		.prog_serial_line_in(line_in), .prog_serial_line_out(line_out),
		.prog_serial_line_oe(line_oe));
	nvm_device_model dev_u (.aclk(aclk), .ser_clk(sclk),
		.ser_in(line_in), .latch_val(latch_v), .ser_out(dev_out),
		.got_stb(got_stb), .got_cmd(got_cmd), .got_opnd(got_opnd),
		.hi_len(hi_len), .lo_len(lo_len));
	// =====================================================
	// Compare and report
	task automatic chk_resp(input string nm, input logic [1:0] e, g);
		checks_done++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask : chk_resp
	task automatic chk_word(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask : chk_word
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			bad_count++;
			results();
		end
	end
	always @(negedge aclk)
	begin
		logic [33:0] e;
		if (bvalid && bready && bq.size() > 0)
			chk_resp("bresp", bq.pop_front(), bresp);
		if (rvalid && rready && rq.size() > 0)
		begin
			e = rq.pop_front();
			chk_resp("rresp", e[33:32], rresp);
			chk_word("rdata", e[31:0], rdata);
		end
		if (got_stb && got_cmd !== 4'h2)
			chk_word("instr", (iq.size() > 0) ? {12'h0, iq.pop_front()}
				: 32'hFFF00000, {12'h0, got_opnd, got_cmd});
	end
	// =====================================================
	// Bus and instruction tasks
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] e);
		logic ha, hw, hb;
		bq.push_back(e);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		hb = 1'b0;
		while (!hb)
		begin
			#1;
			ha = awvalid & awready;
			hw = wvalid & wready;
			hb = bvalid;
			@(posedge aclk);
			if (ha)
				awvalid <= 1'b0;
			if (hw)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic ha, hr;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		hr = 1'b0;
		while (!hr)
		begin
			#1;
			ha = arvalid & arready;
			hr = rvalid;
			d = rdata;
			@(posedge aclk);
			if (ha)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask : rd
	task automatic exr(input logic [7:0] a, input logic [1:0] r,
		input logic [31:0] d);
		logic [31:0] t;
		rq.push_back({r, d});
		rd(a, t);
	endtask : exr
	task automatic idle();
		logic [31:0] t;
		do rd(A_ST, t); while (t[0] !== 1'b0);
	endtask : idle
	task automatic run(input logic [3:0] c, input logic [15:0] o,
		input logic [1:0] h);
		wr(A_OP, {16'h0, o}, 4'h3, OK);
		if (c !== 4'h2)
			iq.push_back({o, c});
		wr(A_CMD, {25'h0, 1'b0, h, c}, 4'h1, OK);
		idle();
	endtask : run
	// =====================================================
	// Main sequence
	initial
	begin
		void'($urandom(97));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		exr(A_OP, OK, 32'h0);
		exr(A_CMD, OK, 32'h0);
		exr(A_ST, OK, 32'h0);
		exr(8'h0C, ERR, 32'h0);
		wr(A_ST, 32'h1, 4'hF, ERR);
		wr(8'h20, 32'h0, 4'hF, ERR);
		wr(A_CMD, 32'h1, 4'h2, ERR);
		wr(A_OP, 32'h0000A5C3, 4'h3, OK);
		wr(A_OP, 32'h00001E00, 4'h2, OK);
		exr(A_OP, OK, 32'h00001EC3);
		$display("test registers done");
		for (int i = 0; i < 9; i++)
			run(cmds[i], 16'($urandom), 2'h0);
		$display("test commands done");
		for (int i = 0; i < 43; i++)
		begin
			run(scr[i][3:0], scr[i][19:4], scr[i][21:20]);
			if (scr[i][21:20] != 2'h0)
			begin
				chk_word("hold_hi", scr[i][21] ? CFG : PROG, hi_len);
				chk_word("hold_lo", DISCH, lo_len);
			end
		end
		$display("test sequences done");
		latch_v <= 8'h86;
		run(4'h2, 16'h0, 2'h0);
		exr(A_ST, OK, 32'h00008600);
		latch_v <= 8'h84;
		run(4'h2, 16'h0, 2'h0);
		exr(A_ST, OK, 32'h00008400);
		wr(A_CMD, 32'h40, 4'h1, OK);
		idle();
		run(4'h0, 16'h94A6, 2'h0);
		$display("test poll and discharge done");
		wr(A_OP, 32'h00006EF5, 4'h3, OK);
		iq.push_back(20'h6EF50);
		wr(A_CMD, 32'h0, 4'h1, OK);
		wr(A_CMD, 32'hD, 4'h1, ERR);
		idle();
		exr(A_ST, OK, 32'h00008400);
		$display("test busy refusal done");
		results();
	end
endmodule : serial_nvm_modify_sequencer_test

// ==== core/serial_nvm_modify_sequencer.sv ====
// Host controller shifting serial programming instructions
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "serial_nvm_params.svh"

// Notes on behaviour
// - Software reads an erase block, edits it, erases and rewrites it.
// - Software sets write enable before using write start.
// - Software polls control register via table latch until start clears.
// - After 1111, NOP 4th clock held high program time, then low.
// - Software repeats load and program until the erased block is rewritten.
// - After EEPROM write clears, clock low for discharge, then disable.
// - Every EEPROM byte repeats the full write sequence.
// - ID write: pointer at ID base, three 1101 loads then 1111.
// - ID bytes are erased before rewriting, as for code memory.
// - Pointer does not advance in config mode; load address each byte.
// - Config starts at pointer 300000h, then low byte 01h.
// - Odd config byte holds clock high for config program time.
// - Write all config bytes before setting config write protection.
// - Each instruction is 4 command bits then 16 operand bits.
// - Host drives bits on rising clock, LSB first; device latches falling.
// - After programming ends the clock stays low for discharge time.
module serial_nvm_modify_sequencer #(
	parameter int unsigned HALF_CYC  = `SNM_HALF_CYC,
	parameter int unsigned TURN_CYC  = `SNM_TURN_CYC,
	parameter int unsigned PROG_CYC  = `SNM_PROG_CYC,
	parameter int unsigned CFG_CYC   = `SNM_CFG_CYC,
	parameter int unsigned DISCH_CYC = `SNM_DISCH_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	output logic             prog_serial_clock,
	input  wire logic        prog_serial_line_in,
	output logic             prog_serial_line_out,
	output logic             prog_serial_line_oe
);
	// =====================================================
	// Declarations
	serial_nvm_pkg::state_e st_r;
	logic        aw_have_r;
	logic        w_have_r;
	logic [7:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic [15:0] operand_r;
	logic [6:0]  command_r;
	logic        go_r;
	logic        busy_r;
	logic [19:0] sh_r;
	logic [4:0]  bit_r;
	logic [31:0] tmr_r;
	logic [1:0]  hold_r;
	logic        disch_r;
	logic [7:0]  rd_r;
	logic        sync1_r;
	logic        sync2_r;
	default clocking chk_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// =====================================================
	// Bus decode
	wire aw_fire   = s_awvalid && s_awready;
	wire w_fire    = s_wvalid && s_wready;
	wire ar_fire   = s_arvalid && s_arready;
	wire wr_do     = aw_have_r && w_have_r && !s_bvalid;
	wire aw_nxt    = (aw_have_r || aw_fire) && !wr_do;
	wire w_nxt     = (w_have_r || w_fire) && !wr_do;
	wire wr_opnd   = awaddr_r == `SNM_ADDR_OPERAND;
	wire wr_cmd    = awaddr_r == `SNM_ADDR_COMMAND;
	wire cmd_ok    = wr_cmd && !busy_r && wstrb_r[0];
	wire wr_ok     = wr_opnd || cmd_ok;
	wire rd_opnd   = s_araddr == `SNM_ADDR_OPERAND;
	wire rd_cmd    = s_araddr == `SNM_ADDR_COMMAND;
	wire rd_stat   = s_araddr == `SNM_ADDR_STATUS;
	wire rd_ok     = rd_opnd || rd_cmd || rd_stat;
	wire [31:0] stat_word = {16'h0000, rd_r, 7'h00, busy_r};
	wire [31:0] rd_word   = rd_opnd ? {16'h0000, operand_r} :
		rd_cmd ? {25'h0000000, command_r} :
		rd_stat ? stat_word : 32'h00000000;
	wire [15:0] opnd_nxt = {wstrb_r[1] ? wdata_r[15:8] : operand_r[15:8],
		wstrb_r[0] ? wdata_r[7:0] : operand_r[7:0]};
	// =====================================================
	// Engine decode
	wire tmr_end  = tmr_r == 32'h00000000;
	wire rd_op    = sh_r[3:0] == `SNM_CMD_SHOUT;
	wire hold_on  = hold_r != `SNM_HOLD_NONE && sh_r[3:0] == `SNM_CMD_CORE;
	wire [31:0] hold_len = (hold_r == `SNM_HOLD_CFG) ?
		32'(CFG_CYC - 1) : 32'(PROG_CYC - 1);
	wire [31:0] hi_next  = (bit_r == 5'h02 && hold_on) ?
		hold_len : 32'(HALF_CYC - 1);
	wire [31:0] lo_next  = (bit_r == 5'h03 && hold_on) ?
		32'(DISCH_CYC - 1) : 32'(HALF_CYC - 1);
	wire [4:0]  bit_inc  = bit_r + 5'h01;
	wire last_bit = bit_r == 5'(`SNM_INSTR_BITS - 1);
	wire turn_at  = rd_op && bit_r == 5'h0B;
	wire reading  = rd_op && bit_r >= 5'h0C;
	// =====================================================
	// Write channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			s_awready <= 1'b0;
			s_wready  <= 1'b0;
			s_bvalid  <= 1'b0;
			s_bresp   <= `SNM_RESP_OKAY;
			awaddr_r  <= 8'h00;
			wdata_r   <= 32'h00000000;
			wstrb_r   <= 4'h0;
			operand_r <= `SNM_RST_OPERAND;
			command_r <= `SNM_RST_COMMAND;
			go_r      <= 1'b0;
		end
		else
		begin
			aw_have_r <= aw_nxt;
			w_have_r  <= w_nxt;
			s_awready <= !aw_nxt;
			s_wready  <= !w_nxt;
			go_r      <= wr_do && cmd_ok;
			if (aw_fire)
				awaddr_r <= s_awaddr;
			if (w_fire)
			begin
				wdata_r <= s_wdata;
				wstrb_r <= s_wstrb;
			end
			if (wr_do && wr_opnd)
				operand_r <= opnd_nxt;
			if (wr_do && cmd_ok)
				command_r <= wdata_r[6:0];
			if (wr_do)
			begin
				s_bvalid <= 1'b1;
				s_bresp  <= wr_ok ? `SNM_RESP_OKAY : `SNM_RESP_SLVERR;
			end
			else if (s_bready)
				s_bvalid <= 1'b0;
		end
	end
	// =====================================================
	// Read channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h00000000;
			s_rresp   <= `SNM_RESP_OKAY;
		end
		else
		begin
			s_arready <= !ar_fire && (!s_rvalid || s_rready);
			if (ar_fire)
			begin
				s_rvalid <= 1'b1;
				s_rdata  <= rd_word;
				s_rresp  <= rd_ok ? `SNM_RESP_OKAY : `SNM_RESP_SLVERR;
			end
			else if (s_rready)
				s_rvalid <= 1'b0;
		end
	end
	// =====================================================
	// Line synchroniser
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
		end
		else
		begin
			sync1_r <= prog_serial_line_in;
			sync2_r <= sync1_r;
		end
	end
	// =====================================================
	// Serial engine
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_r                 <= serial_nvm_pkg::S_IDLE;
			busy_r               <= 1'b0;
			sh_r                 <= 20'h00000;
			bit_r                <= 5'h00;
			tmr_r                <= 32'h00000000;
			hold_r               <= `SNM_HOLD_NONE;
			disch_r              <= 1'b0;
			rd_r                 <= 8'h00;
			prog_serial_clock    <= 1'b0;
			prog_serial_line_out <= 1'b0;
			prog_serial_line_oe  <= 1'b0;
		end
		else
		begin
			if (wr_do && cmd_ok)
				busy_r <= 1'b1;
			if (st_r != serial_nvm_pkg::S_IDLE)
				tmr_r <= tmr_r - 32'h00000001;
			case (st_r)
				serial_nvm_pkg::S_IDLE:
					if (go_r)
					begin
						sh_r    <= {operand_r, command_r[`SNM_F_CMD_HI:`SNM_F_CMD_LO]};
						hold_r  <= command_r[`SNM_F_HOLD_HI:`SNM_F_HOLD_LO];
						disch_r <= command_r[`SNM_F_DISCH];
						bit_r   <= 5'h00;
						if (command_r[`SNM_F_DISCH])
						begin
							st_r  <= serial_nvm_pkg::S_DISCH;
							tmr_r <= 32'(DISCH_CYC - 1);
						end
						else
						begin
							st_r                 <= serial_nvm_pkg::S_HIGH;
							tmr_r                <= 32'(HALF_CYC - 1);
							prog_serial_clock    <= 1'b1;
							prog_serial_line_oe  <= 1'b1;
							prog_serial_line_out <= command_r[0];
						end
					end
				serial_nvm_pkg::S_HIGH:
					if (tmr_end)
					begin
						prog_serial_clock <= 1'b0;
						st_r              <= serial_nvm_pkg::S_LOW;
						tmr_r             <= lo_next;
						if (reading)
							rd_r <= {sync2_r, rd_r[7:1]};
					end
				serial_nvm_pkg::S_LOW, serial_nvm_pkg::S_TURN:
					if (tmr_end)
					begin
						if (last_bit)
						begin
							st_r                <= serial_nvm_pkg::S_IDLE;
							busy_r              <= 1'b0;
							prog_serial_line_oe <= 1'b0;
						end
						else if (turn_at && st_r == serial_nvm_pkg::S_LOW)
						begin
							st_r                <= serial_nvm_pkg::S_TURN;
							tmr_r               <= 32'(TURN_CYC - 1);
							prog_serial_line_oe <= 1'b0;
						end
						else
						begin
							st_r              <= serial_nvm_pkg::S_HIGH;
							bit_r             <= bit_inc;
							tmr_r             <= hi_next;
							prog_serial_clock <= 1'b1;
							prog_serial_line_out <= sh_r[bit_inc];
						end
					end
				serial_nvm_pkg::S_DISCH:
					if (tmr_end)
					begin
						st_r   <= serial_nvm_pkg::S_IDLE;
						busy_r <= 1'b0;
					end
				default:
					st_r <= serial_nvm_pkg::S_IDLE;
			endcase
		end
	end
	// =====================================================
	// Checks
	logic [31:0] hc_r;
	logic [31:0] lc_r;
	logic [4:0]  rc_r;
	logic        clk_q_r;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			hc_r    <= 32'h00000000;
			lc_r    <= 32'h00000000;
			rc_r    <= 5'h00;
			clk_q_r <= 1'b0;
		end
		else
		begin
			clk_q_r <= prog_serial_clock;
			hc_r <= prog_serial_clock ? hc_r + 32'h00000001 : 32'h00000000;
			lc_r <= (prog_serial_clock || go_r) ? 32'h00000000 :
				lc_r + 32'h00000001;
			if (st_r == serial_nvm_pkg::S_IDLE)
				rc_r <= 5'h00;
			else if (prog_serial_clock && !clk_q_r)
				rc_r <= rc_r + 5'h01;
		end
	end
	property p_lsb_on_rise;
		prog_serial_line_oe && $past(prog_serial_line_oe) &&
		$changed(prog_serial_line_out) |-> $rose(prog_serial_clock);
	endproperty
	a_lsb_on_rise: assert property (p_lsb_on_rise)
		else $error("line changed away from a rising clock");
	property p_release_low;
		$fell(prog_serial_line_oe) |-> !prog_serial_clock;
	endproperty
	a_release_low: assert property (p_release_low)
		else $error("line released while clock high");
	property p_twenty_clocks;
		$fell(busy_r) && !disch_r |-> rc_r == 5'(`SNM_INSTR_BITS);
	endproperty
	a_twenty_clocks: assert property (p_twenty_clocks)
		else $error("instruction did not have twenty clocks");
	property p_prog_hold;
		$fell(prog_serial_clock) && hc_r > 32'(HALF_CYC) &&
		hold_r == `SNM_HOLD_PROG |-> hc_r == 32'(PROG_CYC);
	endproperty
	a_prog_hold: assert property (p_prog_hold)
		else $error("program hold length wrong");
	property p_cfg_hold;
		$fell(prog_serial_clock) && hc_r > 32'(HALF_CYC) &&
		hold_r == `SNM_HOLD_CFG |-> hc_r == 32'(CFG_CYC);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold)
		else $error("config hold length wrong");
	property p_discharge_after_hold;
		$fell(prog_serial_clock) && hc_r > 32'(HALF_CYC) |->
		!prog_serial_clock [*8];
	endproperty
	a_discharge_after_hold: assert property (p_discharge_after_hold)
		else $error("clock rose early after hold");
	property p_discharge_len;
		$rose(prog_serial_clock) && bit_r == 5'h04 && hold_on |->
		lc_r == 32'(DISCH_CYC);
	endproperty
	a_discharge_len: assert property (p_discharge_len)
		else $error("discharge after hold too short");
	property p_discharge_only;
		$fell(busy_r) && disch_r |->
		!prog_serial_clock && lc_r == 32'(DISCH_CYC);
	endproperty
	a_discharge_only: assert property (p_discharge_only)
		else $error("discharge command too short");
	c_read_byte: cover property ($fell(busy_r) && rd_op);
	c_prog_hold: cover property ($fell(prog_serial_clock) &&
		hc_r > 32'(HALF_CYC));
	c_discharge: cover property ($fell(busy_r) && disch_r);
endmodule : serial_nvm_modify_sequencer

// ==== pkg/serial_nvm_params.svh ====
// Register map, field positions, reset values and timing counts
`ifndef SERIAL_NVM_PARAMS_SVH
`define SERIAL_NVM_PARAMS_SVH
// =========================================================
// Register offsets
`define SNM_ADDR_OPERAND 8'h00
`define SNM_ADDR_COMMAND 8'h04
`define SNM_ADDR_STATUS  8'h08
// =========================================================
// Field positions
`define SNM_F_CMD_HI     3
`define SNM_F_CMD_LO     0
`define SNM_F_HOLD_HI    5
`define SNM_F_HOLD_LO    4
`define SNM_F_DISCH      6
`define SNM_F_BUSY       0
`define SNM_F_RDATA_HI   15
`define SNM_F_RDATA_LO   8
// =========================================================
// Codes and reset values
`define SNM_HOLD_NONE    2'h0
`define SNM_HOLD_PROG    2'h1
`define SNM_HOLD_CFG     2'h2
`define SNM_CMD_CORE     4'h0
`define SNM_CMD_SHOUT    4'h2
`define SNM_RST_OPERAND  16'h0000
`define SNM_RST_COMMAND  7'h00
`define SNM_INSTR_BITS   20
`define SNM_RESP_OKAY    2'h0
`define SNM_RESP_SLVERR  2'h2
// =========================================================
// Timing
`define SNM_CLK_NS       10
`define SNM_HALF_NS      40
`define SNM_TURN_NS      40
`define SNM_PROG_HOLD_NS 1000000
`define SNM_CFG_HOLD_NS  5000000
`define SNM_DISCH_NS     100000
`define SNM_CYC(t)       (((t) + `SNM_CLK_NS - 1) / `SNM_CLK_NS)
`define SNM_HALF_CYC     `SNM_CYC(`SNM_HALF_NS)
`define SNM_TURN_CYC     `SNM_CYC(`SNM_TURN_NS)
`define SNM_PROG_CYC     `SNM_CYC(`SNM_PROG_HOLD_NS)
`define SNM_CFG_CYC      `SNM_CYC(`SNM_CFG_HOLD_NS)
`define SNM_DISCH_CYC    `SNM_CYC(`SNM_DISCH_NS)
`endif

// ==== pkg/serial_nvm_pkg.sv ====
// Types shared by the serial programming controller
package serial_nvm_pkg;
	// =====================================================
	// Engine states
	typedef enum logic [2:0] {
		S_IDLE,
		S_HIGH,
		S_LOW,
		S_TURN,
		S_DISCH
	} state_e;
endpackage : serial_nvm_pkg
